// ==== inc/rapidio_alias_pkg.sv ====
package rapidio_alias_pkg;

    // Bus and bank geometry
    localparam int unsigned ADDR_W     = 17;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned NUM_REG    = 10;
    localparam int unsigned SLOT_W     = 4;
    localparam int unsigned KEY_W      = 16;
    localparam int unsigned ALIAS_BITS = 12;

    // Aliasing windows
    localparam logic [16:0] MAC_WIN_LO = 17'h1B400;
    localparam logic [16:0] MAC_WIN_HI = 17'h1B9FC;
    localparam logic [16:0] MAP_WIN_LO = 17'h00400;
    localparam logic [16:0] MAP_WIN_HI = 17'h009FC;

    // Inbound message unit mapping registers
    localparam logic [16:0] INBOUND_MAP11_E01_UPPER_OFS = 17'h00410;
    localparam logic [16:0] INBOUND_MAP11_E12_LOWER_OFS = 17'h00490;
    localparam logic [16:0] INBOUND_MAP11_E22_QUEUE_OFS = 17'h00510;
    localparam logic [16:0] INBOUND_MAP9_E45_WORD2_OFS  = 17'h00924;
    localparam logic [16:0] INBOUND_MAP9_E47_WORD0_OFS  = 17'h00934;
    localparam logic [16:0] INBOUND_MAP9_E47_WORD2_OFS  = 17'h0093C;
    localparam logic [16:0] INBOUND_MAP9_E49_WORD0_OFS  = 17'h0094C;
    localparam logic [16:0] INBOUND_MAP9_E49_WORD1_OFS  = 17'h00950;
    localparam logic [16:0] INBOUND_MAP9_E50_WORD2_OFS  = 17'h00960;
    localparam logic [16:0] INBOUND_MAP9_E52_WORD0_OFS  = 17'h00970;

    // MAC registers sharing low address bits with the entries above
    localparam logic [16:0] PORT1_TRANSPORT_STATE_OFS   = 17'h1B410;
    localparam logic [16:0] PORT2_TRANSPORT_STATE_OFS   = 17'h1B490;
    localparam logic [16:0] PORT3_TRANSPORT_STATE_OFS   = 17'h1B510;
    localparam logic [16:0] EVENT_PW_ENABLE_OFS         = 17'h1B924;
    localparam logic [16:0] EVENT_DEV_PW_ENABLE_OFS     = 17'h1B934;
    localparam logic [16:0] EVENT_MC_CTL_STATE_OFS      = 17'h1B93C;
    localparam logic [16:0] EVENT_MC_CTL_REQUEST_OFS    = 17'h1B94C;
    localparam logic [16:0] EVENT_MC_CTL_PORT_STATE_OFS = 17'h1B950;
    localparam logic [16:0] EVENT_RESET_PORT_STATE_OFS  = 17'h1B960;
    localparam logic [16:0] EVENT_RESET_PW_ENABLE_OFS   = 17'h1B970;

    // Bank index order; MAP_OFS[i] is the alias partner of MAC_OFS[i]
    localparam logic [16:0] MAP_OFS [NUM_REG] = '{
        INBOUND_MAP11_E01_UPPER_OFS, INBOUND_MAP11_E12_LOWER_OFS,
        INBOUND_MAP11_E22_QUEUE_OFS, INBOUND_MAP9_E45_WORD2_OFS,
        INBOUND_MAP9_E47_WORD0_OFS,  INBOUND_MAP9_E47_WORD2_OFS,
        INBOUND_MAP9_E49_WORD0_OFS,  INBOUND_MAP9_E49_WORD1_OFS,
        INBOUND_MAP9_E50_WORD2_OFS,  INBOUND_MAP9_E52_WORD0_OFS};
    localparam logic [16:0] MAC_OFS [NUM_REG] = '{
        PORT1_TRANSPORT_STATE_OFS, PORT2_TRANSPORT_STATE_OFS,
        PORT3_TRANSPORT_STATE_OFS, EVENT_PW_ENABLE_OFS,
        EVENT_DEV_PW_ENABLE_OFS,   EVENT_MC_CTL_STATE_OFS,
        EVENT_MC_CTL_REQUEST_OFS,  EVENT_MC_CTL_PORT_STATE_OFS,
        EVENT_RESET_PORT_STATE_OFS, EVENT_RESET_PW_ENABLE_OFS};

    // Transport type field and the words that carry it
    localparam int unsigned TYPE_FIELD_LSB   = 13;
    localparam logic [1:0]  TYPE_FIELD_OFF   = 2'h3;
    localparam logic [9:0]  TYPE_FIELD_SLOTS = 10'h081;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [16:0]       addr;
        logic [31:0]       wdata;
    } reg_req_t;

    typedef struct packed {
        logic              valid;
        logic [3:0]        slot;
        logic [15:0]       key;
    } msg_req_t;

    typedef struct packed {
        logic [9:0][31:0]  map;
        logic [9:0][31:0]  mac;
        logic [31:0]       rdata;
    } bank_state_t;

    typedef struct packed {
        logic              admit;
        logic              valid;
    } admit_state_t;

    // Offset inside the faulty MAC decode window
    function automatic logic in_mac_window(input logic [16:0] addr);
        return (addr >= MAC_WIN_LO) && (addr <= MAC_WIN_HI);
    endfunction

    // Mapping offset that shares the low address bits
    function automatic logic [16:0] alias_target(input logic [16:0] addr);
        return {5'h00, addr[ALIAS_BITS-1:0]};
    endfunction

    // Entry word with its transport type field set to disabled
    function automatic logic type_field_off(input logic [31:0] word);
        return word[TYPE_FIELD_LSB +: 2] == TYPE_FIELD_OFF;
    endfunction

endpackage

// ==== design/alias_write_steer.sv ====
`timescale 1ns/100ps
`default_nettype none

module alias_write_steer
    import rapidio_alias_pkg::*;
(
    input  wire reg_req_t     req_i,
    output logic [NUM_REG-1:0] mac_we_o,
    output logic [NUM_REG-1:0] map_we_o
);

    // Write enables per bank word, including the faulty alias path
    always_comb begin
        mac_we_o = '0;
        map_we_o = '0;
        for (int i = 0; i < NUM_REG; i++) begin
            if (req_i.wr && req_i.addr == MAC_OFS[i]) begin
                mac_we_o[i] = 1'b1;
            end
            if (req_i.wr && req_i.addr == MAP_OFS[i]) begin
                map_we_o[i] = 1'b1;
            end
            if (req_i.wr && in_mac_window(req_i.addr)
                && alias_target(req_i.addr) == MAP_OFS[i]) begin
                map_we_o[i] = 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/msg_admit_check.sv ====
`timescale 1ns/100ps
`default_nettype none

module msg_admit_check
    import rapidio_alias_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rst_b_i,
    input  wire msg_req_t         msg_i,
    input  wire logic [9:0][31:0] map_i,
    output logic                  admit_o,
    output logic                  admit_valid_o
);

    admit_state_t st_r;
    admit_state_t st_nxt;

    // Verdict from the current mapping words
    always_comb begin
        logic [31:0] word;
        word = REG_RESET;
        st_nxt = '0;
        st_nxt.valid = msg_i.valid;
        if (msg_i.valid && msg_i.slot < SLOT_W'(NUM_REG)) begin
            word = map_i[msg_i.slot];
            st_nxt.admit = (word[KEY_W-1:0] == msg_i.key)
                && !(TYPE_FIELD_SLOTS[msg_i.slot] && type_field_off(word));
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign admit_o       = st_r.admit;
    assign admit_valid_o = st_r.valid;

endmodule
`default_nettype wire

// ==== design/rapidio_reg_alias_decode.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - A write in the MAC window 1B400h to 1B9FCh stores its data in the addressed MAC word.
// - Such a write also stores the data in the mapping word whose low 12 address bits match.
// - Mapping word contents decide whether an arriving message is admitted.
// - A transport type field of 11b disables its entry, set by software at initialisation.
// - Each listed register decodes at the block base plus its listed offset.
// - Port 2 transport state at 1B490h aliases onto entry 12 lower word at 00490h, the rest alike.
// - Port 1 transport state and multicast port state land in a transport type word.
// - The transport type field sits at bits 14:13 of entry 01 upper and entry 49 word 1.
module rapidio_reg_alias_decode
    import rapidio_alias_pkg::*;
#(
    parameter int unsigned NUM_WORDS = NUM_REG
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_b_i,
    input  wire logic [16:0]   reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [31:0]   reg_rdata_o,
    input  wire logic          msg_valid_i,
    input  wire logic [3:0]    msg_slot_i,
    input  wire logic [15:0]   msg_key_i,
    output logic               msg_admit_o,
    output logic               msg_admit_valid_o
);

    // Elaboration check on the bank size
    if (NUM_WORDS != NUM_REG) begin : g_size_check
        $error("bank size must match the aliased register list");
    end

    reg_req_t          req;
    msg_req_t          msg;
    logic [NUM_REG-1:0] mac_we;
    logic [NUM_REG-1:0] map_we;
    bank_state_t       st_r;
    bank_state_t       st_nxt;

    // Bundle the bus and message ports
    assign req.wr    = reg_wr_i;
    assign req.rd    = reg_rd_i;
    assign req.addr  = reg_addr_i;
    assign req.wdata = reg_wdata_i;
    assign msg.valid = msg_valid_i;
    assign msg.slot  = msg_slot_i;
    assign msg.key   = msg_key_i;

    // Address decode with the alias path
    alias_write_steer u_steer (
        .req_i    (req),
        .mac_we_o (mac_we),
        .map_we_o (map_we)
    );

    // Read word lookup; unmapped offsets read zero
    function automatic logic [31:0] read_word(
        input logic [16:0] addr,
        input bank_state_t st
    );
        logic [31:0] val;
        val = REG_RESET;
        for (int i = 0; i < NUM_REG; i++) begin
            if (addr == MAC_OFS[i]) begin
                val = st.mac[i];
            end
            if (addr == MAP_OFS[i]) begin
                val = st.map[i];
            end
        end
        return val;
    endfunction

    // Next state of the register bank
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = REG_RESET;
        for (int i = 0; i < NUM_REG; i++) begin
            if (mac_we[i]) begin
                st_nxt.mac[i] = reg_wdata_i;
            end
            if (map_we[i]) begin
                st_nxt.map[i] = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            st_nxt.rdata = read_word(reg_addr_i, st_r);
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;

    // Admission check on live mapping words
    msg_admit_check u_admit (
        .mclk_i        (mclk_i),
        .rst_b_i       (rst_b_i),
        .msg_i         (msg),
        .map_i         (st_r.map),
        .admit_o       (msg_admit_o),
        .admit_valid_o (msg_admit_valid_o)
    );

    // MAC write lands in its own word
    property p_mac_store;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == PORT3_TRANSPORT_STATE_OFS)
        |=> (st_r.mac[2] == $past(reg_wdata_i));
    endproperty
    a_mac_store: assert property (p_mac_store)
        else $error("MAC write did not store");

    // Alias copy reaches the partner mapping word
    property p_alias_copy;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == PORT2_TRANSPORT_STATE_OFS)
        |=> (st_r.map[1] == $past(reg_wdata_i))
            && (st_r.mac[1] == st_r.map[1]);
    endproperty
    a_alias_copy: assert property (p_alias_copy)
        else $error("alias write missed the mapping word");

    // Alias copy visible on a later read
    property p_alias_read;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == EVENT_RESET_PW_ENABLE_OFS)
        ##1 (reg_rd_i && !reg_wr_i
             && reg_addr_i == INBOUND_MAP9_E52_WORD0_OFS)
        |=> (reg_rdata_o == $past(reg_wdata_i, 2));
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("aliased value not read back");

    // Window write with no partner leaves the mapping words alone
    property p_no_partner;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == MAC_WIN_LO)
        |=> (st_r.map == $past(st_r.map));
    endproperty
    a_no_partner: assert property (p_no_partner)
        else $error("mapping word changed without a partner");

    // Mapping write outside the window stays local
    property p_local_write;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == INBOUND_MAP11_E12_LOWER_OFS)
        |=> (st_r.mac == $past(st_r.mac))
            && (st_r.map[0] == $past(st_r.map[0]))
            && (st_r.map[1] == $past(reg_wdata_i));
    endproperty
    a_local_write: assert property (p_local_write)
        else $error("outside write touched another word");

    // Multicast port state write disables entry 49
    property p_type_direct;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == EVENT_MC_CTL_PORT_STATE_OFS
         && reg_wdata_i[TYPE_FIELD_LSB +: 2] == TYPE_FIELD_OFF)
        |=> type_field_off(st_r.map[7]);
    endproperty
    a_type_direct: assert property (p_type_direct)
        else $error("transport type word not disabled");

    // A disabled entry 01 never admits
    property p_type_reject;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (msg_valid_i && msg_slot_i == 4'h0 && type_field_off(st_r.map[0]))
        |=> msg_admit_valid_o && !msg_admit_o;
    endproperty
    a_type_reject: assert property (p_type_reject)
        else $error("disabled entry admitted a message");

    // Matching enabled entry admits one cycle later
    property p_admit;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (msg_valid_i && msg_slot_i == 4'h1
         && st_r.map[1][15:0] == msg_key_i)
        |=> msg_admit_o && msg_admit_valid_o;
    endproperty
    a_admit: assert property (p_admit)
        else $error("matching entry refused a message");

    // Read data stand one cycle only
    property p_read_slot;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == PORT1_TRANSPORT_STATE_OFS)
        ##1 !reg_rd_i
        |-> (reg_rdata_o == $past(st_r.mac[0])) ##1 (reg_rdata_o == 32'h0);
    endproperty
    a_read_slot: assert property (p_read_slot)
        else $error("read data wrong or held too long");

    // Read data fall back to zero without a read
    property p_rdata_idle;
        @(posedge mclk_i) disable iff (!rst_b_i)
        !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stand without a read");

    // Every message gets a verdict one cycle later
    property p_admit_pulse;
        @(posedge mclk_i) disable iff (!rst_b_i)
        msg_valid_i |=> msg_admit_valid_o;
    endproperty
    a_admit_pulse: assert property (p_admit_pulse)
        else $error("message verdict missing");

    // No message, no verdict
    property p_admit_quiet;
        @(posedge mclk_i) disable iff (!rst_b_i)
        !msg_valid_i |=> !msg_admit_valid_o && !msg_admit_o;
    endproperty
    a_admit_quiet: assert property (p_admit_quiet)
        else $error("verdict without a message");

    // Slots past the bank never admit
    property p_slot_range;
        @(posedge mclk_i) disable iff (!rst_b_i)
        msg_valid_i && msg_slot_i >= 4'hA |=> !msg_admit_o;
    endproperty
    a_slot_range: assert property (p_slot_range)
        else $error("unmapped slot admitted a message");

    // Key mismatch refuses the message
    property p_key_miss;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (msg_valid_i && msg_slot_i == 4'h1
         && st_r.map[1][15:0] != msg_key_i) |=> !msg_admit_o;
    endproperty
    a_key_miss: assert property (p_key_miss)
        else $error("wrong key admitted a message");

    // Disabled entry 49 never admits
    property p_type7_reject;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (msg_valid_i && msg_slot_i == 4'h7 && type_field_off(st_r.map[7]))
        |=> msg_admit_valid_o && !msg_admit_o;
    endproperty
    a_type7_reject: assert property (p_type7_reject)
        else $error("disabled entry 49 admitted a message");

    // Enabled entry 49 with matching key admits
    property p_type7_open;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (msg_valid_i && msg_slot_i == 4'h7 && !type_field_off(st_r.map[7])
         && st_r.map[7][15:0] == msg_key_i) |=> msg_admit_o;
    endproperty
    a_type7_open: assert property (p_type7_open)
        else $error("enabled entry 49 refused a message");

    // Port 1 state write lands in its word and in entry 01 upper
    property p_port1_alias;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == PORT1_TRANSPORT_STATE_OFS)
        |=> (st_r.map[0] == $past(reg_wdata_i)) && (st_r.mac[0] == $past(reg_wdata_i));
    endproperty
    a_port1_alias: assert property (p_port1_alias)
        else $error("port 1 state write missed a word");

    // Multicast port state write lands in both words
    property p_mc_port_alias;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == EVENT_MC_CTL_PORT_STATE_OFS)
        |=> (st_r.map[7] == $past(reg_wdata_i)) && (st_r.mac[7] == $past(reg_wdata_i));
    endproperty
    a_mc_port_alias: assert property (p_mc_port_alias)
        else $error("multicast port state write missed a word");

    // Port 1 state write with 11b keeps entry 01 disabled
    property p_port1_type;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == PORT1_TRANSPORT_STATE_OFS
         && reg_wdata_i[TYPE_FIELD_LSB +: 2] == TYPE_FIELD_OFF) |=> type_field_off(st_r.map[0]);
    endproperty
    a_port1_type: assert property (p_port1_type)
        else $error("entry 01 not disabled by port 1 write");

    // Direct entry 49 word 1 write stays local
    property p_e49_local;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == INBOUND_MAP9_E49_WORD1_OFS)
        |=> (st_r.mac == $past(st_r.mac)) && (st_r.map[7] == $past(reg_wdata_i));
    endproperty
    a_e49_local: assert property (p_e49_local)
        else $error("entry 49 write touched a MAC word");

    // Mapping word read returns its content
    property p_read_map;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == INBOUND_MAP9_E49_WORD1_OFS)
        |=> (reg_rdata_o == $past(st_r.map[7]));
    endproperty
    a_read_map: assert property (p_read_map)
        else $error("mapping word read wrong");

    // MAC word read returns its content
    property p_read_mac;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == EVENT_RESET_PW_ENABLE_OFS)
        |=> (reg_rdata_o == $past(st_r.mac[9]));
    endproperty
    a_read_mac: assert property (p_read_mac)
        else $error("MAC word read wrong");

    // Unmapped offset reads zero
    property p_read_hole;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == MAP_WIN_LO) |=> (reg_rdata_o == 32'h0000_0000);
    endproperty
    a_read_hole: assert property (p_read_hole)
        else $error("unmapped offset read nonzero");

    // Words hold without a write
    property p_hold;
        @(posedge mclk_i) disable iff (!rst_b_i)
        !reg_wr_i
        |=> (st_r.map == $past(st_r.map)) && (st_r.mac == $past(st_r.mac));
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed without a write");

    // Reset port write enable aliases onto entry 52 word 0
    property p_alias_e52;
        @(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == EVENT_RESET_PW_ENABLE_OFS)
        |=> (st_r.map[9] == $past(reg_wdata_i));
    endproperty
    a_alias_e52: assert property (p_alias_e52)
        else $error("entry 52 missed the alias copy");

endmodule
`default_nettype wire

// ==== sim/tb_rapidio_reg_alias_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_rapidio_reg_alias_decode
    import rapidio_alias_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [16:0] reg_addr = 17'h00000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        msg_valid = 1'b0;
    logic [3:0]  msg_slot = 4'h0;
    logic [15:0] msg_key = 16'h0000;
    logic        msg_admit;
    logic        msg_admit_valid;
    int          miscompares = 0;
    int          tests_run = 0;

    // Free running 250 MHz clock
    always #2 mclk = ~mclk;

    rapidio_reg_alias_decode #(
        .NUM_WORDS         (10)
    ) rapidio_reg_alias_decode_i (
        .mclk_i            (mclk),
        .rst_b_i           (rst_b),
        .reg_addr_i        (reg_addr),
        .reg_wdata_i       (reg_wdata),
        .reg_wr_i          (reg_wr),
        .reg_rd_i          (reg_rd),
        .reg_rdata_o       (reg_rdata),
        .msg_valid_i       (msg_valid),
        .msg_slot_i        (msg_slot),
        .msg_key_i         (msg_key),
        .msg_admit_o       (msg_admit),
        .msg_admit_valid_o (msg_admit_valid)
    );

    // Counts and verdict, the single end of the run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One comparison with immediate report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single cycle register write
    task automatic reg_write(input logic [16:0] addr, input logic [31:0] data);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Single cycle read, data checked in the following cycle
    task automatic reg_check(input string what, input logic [16:0] addr, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    // Message arrival, verdict one cycle later
    task automatic msg_check(input logic [3:0] slot, input logic [15:0] key, input logic exp);
        @(posedge mclk);
        msg_valid <= 1'b1;
        msg_slot  <= slot;
        msg_key   <= key;
        @(posedge mclk);
        msg_valid <= 1'b0;
        #1;
        check("admit valid", 32'h1, {31'h0, msg_admit_valid});
        check("admit", {31'h0, exp}, {31'h0, msg_admit});
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        $display("mismatch watchdog expected done seen timeout");
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < NUM_REG; i++) begin
            reg_check("map reset", MAP_OFS[i], 32'h0000_0000);
            reg_check("mac reset", MAC_OFS[i], 32'h0000_0000);
        end
        // MAC writes first, transport type bits kept at 11b
        for (int i = 0; i < NUM_REG; i++) begin
            reg_write(MAC_OFS[i], 32'hC3C3_6000 + 32'(i));
            reg_check("mac word", MAC_OFS[i], 32'hC3C3_6000 + 32'(i));
            reg_check("alias word", MAP_OFS[i], 32'hC3C3_6000 + 32'(i));
        end
        @(posedge mclk);
        #1;
        check("rdata idle", 32'h0000_0000, reg_rdata);
        msg_check(4'h0, 16'h6000, 1'b0);
        msg_check(4'h7, 16'h6007, 1'b0);
        msg_check(4'h1, 16'h6001, 1'b1);
        // Mapping words programmed after the MAC words
        for (int i = 0; i < NUM_REG; i++) begin
            reg_write(MAP_OFS[i], 32'h0000_1230 + 32'(i));
            reg_check("map word", MAP_OFS[i], 32'h0000_1230 + 32'(i));
            reg_check("mac kept", MAC_OFS[i], 32'hC3C3_6000 + 32'(i));
        end
        msg_check(4'h1, 16'h1231, 1'b1);
        msg_check(4'h1, 16'h1232, 1'b0);
        msg_check(4'h0, 16'h1230, 1'b1);
        msg_check(4'hA, 16'h0000, 1'b0);
        reg_write(MAP_OFS[7], 32'h0000_7237);
        msg_check(4'h7, 16'h7237, 1'b0);
        reg_write(MAP_OFS[7], 32'h0000_4237);
        msg_check(4'h7, 16'h4237, 1'b1);
        // Late MAC write corrupts its mapping partner
        reg_write(MAC_OFS[1], 32'hDEAD_0000);
        reg_check("late alias", MAP_OFS[1], 32'hDEAD_0000);
        msg_check(4'h1, 16'h1231, 1'b0);
        // Window offset without a listed register
        reg_write(MAC_WIN_LO, 32'h5555_AAAA);
        reg_check("hole map", MAP_WIN_LO, 32'h0000_0000);
        reg_check("hole mac", MAC_WIN_LO, 32'h0000_0000);
        reg_check("map untouched", MAP_OFS[0], 32'h0000_1230);
        // Affected entries stay disabled while MAC words change later
        reg_write(MAP_OFS[0], 32'h0000_6230);
        reg_write(MAC_OFS[0], 32'h0001_6230);
        reg_check("port1 alias", MAP_OFS[0], 32'h0001_6230);
        msg_check(4'h0, 16'h6230, 1'b0);
        reg_write(MAC_OFS[7], 32'h0002_6237);
        msg_check(4'h7, 16'h6237, 1'b0);
        // Back to back write and read of the alias partner
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= MAC_OFS[9];
        reg_wdata <= 32'h5A5A_0009;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        reg_addr  <= MAP_OFS[9];
        @(posedge mclk);
        reg_rd    <= 1'b0;
        #1;
        check("back to back", 32'h5A5A_0009, reg_rdata);
        // Reset in mid-run clears the bank
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        reg_check("map after reset", MAP_OFS[1], 32'h0000_0000);
        complete_run();
    end
endmodule

`default_nettype wire
